//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic       sys_clk, rst_n, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [8:0] got, word;
  logic       dt_out, dt_oe, ck_out, ck_oe, g_dout, g_doe, g_cout, g_coe;
  logic       listen, sync_mode, nine, slv_go, slv_clk, stop_ok;
  logic [9:0] bit_cyc;
  int         frames, miscompares, n_checks;
  logic [23:0] rows [10] = '{24'h15fff3, 24'h150002, 24'h13fff0, 24'h130000, 24'h175a5a,
                             24'h170000, 24'h20ff00, 24'h190303, 24'h190000, 24'h180300};
  wire        tx_line = ck_oe ? ck_out : slv_clk;  // Peer holds clock low when idle
  wire        dt_line = dt_oe ? dt_out : 1'b1;     // Pull-up on data pin

  usm_top i_usm_top (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .receive_data_pin_in(dt_line), .receive_data_pin_out(dt_out),
    .receive_data_pin_oe(dt_oe), .transmit_clock_pin_in(tx_line),
    .transmit_clock_pin_out(ck_out), .transmit_clock_pin_oe(ck_oe), .gpio_data_out(g_dout),
    .gpio_data_oe(g_doe), .gpio_clock_out(g_cout), .gpio_clock_oe(g_coe));
  usm_peer i_usm_peer (.sys_clk, .tx_line, .dt_line, .listen, .sync_mode, .nine, .bit_cyc,
    .slv_go, .slv_clk, .word, .stop_ok, .frames);

  // Clock
  always #25 sys_clk = ~sys_clk;

  task chk(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = {1'b0, reg_rdata};
  endtask : rd
  task wrap_up;
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task wait_frames(input int n, input int lim);
    for (int i = 0; i < lim && frames != n; i++) @(posedge sys_clk);
    if (frames != n) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_frames

  // Main sequence
  initial begin
    sys_clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    g_dout = 0; g_doe = 0; g_cout = 1; g_coe = 0; listen = 0; sync_mode = 0; nine = 0;
    slv_go = 0; bit_cyc = 10'd64; miscompares = 0; n_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h15);
    chk(got, 9'h002);
    chk({8'h00, irq}, 9'h000);
    @(posedge sys_clk);
    g_doe <= 1'b1;
    g_dout <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk({7'h00, dt_oe, dt_out}, 9'h003);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(got, {1'b0, rows[i][7:0]});
    end
    // Async 8-bit frame with interrupt
    wr(8'h19, 8'h03);
    wr(8'h13, 8'h80);
    wr(8'h15, 8'h20);
    listen <= 1'b1;
    wr(8'h16, 8'ha5);
    repeat (20) @(posedge sys_clk);
    rd(8'h15);
    chk(got, 9'h020);
    wait_frames(1, 20000);
    chk(word, 9'h0a5);
    chk({8'h00, stop_ok}, 9'h001);
    repeat (100) @(posedge sys_clk);
    rd(8'h18);
    chk(got, 9'h003);
    chk({8'h00, irq}, 9'h001);
    wr(8'h18, 8'h03);
    repeat (3) @(posedge sys_clk);
    chk({8'h00, irq}, 9'h000);
    // Async 9-bit frame, divisor 1, interrupt masked
    wr(8'h19, 8'h00);
    wr(8'h17, 8'h01);
    bit_cyc <= 10'd128;
    nine <= 1'b1;
    wr(8'h15, 8'h61);
    wr(8'h16, 8'h3c);
    wait_frames(2, 20000);
    chk(word, 9'h13c);
    repeat (300) @(posedge sys_clk);
    chk({8'h00, irq}, 9'h000);
    // Sync master frame
    listen <= 1'b0;
    nine <= 1'b0;
    sync_mode <= 1'b1;
    wr(8'h17, 8'hff);
    repeat (100) @(posedge sys_clk);
    wr(8'h17, 8'h00);
    wr(8'h15, 8'hb0);
    repeat (10) @(posedge sys_clk);
    listen <= 1'b1;
    wr(8'h16, 8'h96);
    wait_frames(3, 100);
    chk(word, 9'h096);
    // Receive enable holds transmit off
    wr(8'h13, 8'h90);
    wr(8'h16, 8'h55);
    repeat (200) @(posedge sys_clk);
    rd(8'h15);
    chk(got, 9'h0b2);
    wr(8'h13, 8'h80);
    wait_frames(4, 20000);
    chk(word, 9'h055);
    // Sync slave frame on peer clock
    listen <= 1'b0;
    wr(8'h15, 8'h30);
    repeat (10) @(posedge sys_clk);
    listen <= 1'b1;
    wr(8'h16, 8'h4b);
    repeat (10) @(posedge sys_clk);
    slv_go <= 1'b1;
    wait_frames(5, 20000);
    chk(word, 9'h04b);
    wrap_up();
  end
endmodule : tb

bind usm_top usm_checker i_usm_checker (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .receive_data_pin_out, .receive_data_pin_oe, .transmit_clock_pin_out,
  .transmit_clock_pin_oe, .gpio_data_out, .gpio_data_oe, .gpio_clock_oe);

//--- dv/usm_checker.sv
`timescale 1ns/1ps
// ********
// Port checker
// ********
module usm_checker (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       receive_data_pin_out,
  input wire logic       receive_data_pin_oe,
  input wire logic       transmit_clock_pin_out,
  input wire logic       transmit_clock_pin_oe,
  input wire logic       gpio_data_out,
  input wire logic       gpio_data_oe,
  input wire logic       gpio_clock_oe
);
  logic [3:0] rx_reg;
  logic [4:0] tx_reg;
  logic [7:0] div_reg;
  logic       ok_reg;
  logic [9:0] lo_reg;
  wire        serial_port_enable    = rx_reg[3];
  wire        sync    = tx_reg[1];
  wire        transmit_enable_bit    = tx_reg[2];
  wire        clock_source_select    = tx_reg[4];
  wire        dt_en   = transmit_enable_bit && !rx_reg[1] && !rx_reg[0];
  wire  [7:0] tx_view = {tx_reg[4:1], 3'h0, tx_reg[0]};
  wire  [7:0] rx_view = {rx_reg, 4'h0};
  wire        ok      = serial_port_enable && !sync && transmit_enable_bit && div_reg == 8'h00;

  // Shadow copy of the control bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_reg <= 4'h0;
      tx_reg <= 5'h00;
      div_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h13) rx_reg <= reg_wdata[7:4];
      if (reg_addr == 8'h15) tx_reg <= {reg_wdata[7:4], reg_wdata[0]};
      if (reg_addr == 8'h17) div_reg <= reg_wdata;
    end
  end

  // Length of each low run on the async line
  always_ff @(posedge sys_clk) begin
    ok_reg <= rst_n && ok;
    lo_reg <= (!ok_reg || transmit_clock_pin_out) ? 10'h000 : lo_reg + 10'h001;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_rd;
    reg_rd && reg_addr == 8'h15;
  endsequence
  sequence s_rx_rd;
    reg_rd && reg_addr == 8'h13;
  endsequence

  property p_tx_rd;
    s_tx_rd |=> (reg_rdata & 8'hfd) == $past(tx_view);
  endproperty
  a_tx_rd: assert property (p_tx_rd) else $error("tx control readback wrong");
  property p_rx_rd;
    s_rx_rd |=> reg_rdata == $past(rx_view);
  endproperty
  a_rx_rd: assert property (p_rx_rd) else $error("rx control readback wrong");
  property p_gpio_d;
    !serial_port_enable |=> receive_data_pin_oe == $past(gpio_data_oe)
          && receive_data_pin_out == $past(gpio_data_out);
  endproperty
  a_gpio_d: assert property (p_gpio_d) else $error("data pin not general io");
  property p_gpio_c;
    !serial_port_enable |=> transmit_clock_pin_oe == $past(gpio_clock_oe);
  endproperty
  a_gpio_c: assert property (p_gpio_c) else $error("clock pin not general io");
  property p_async_oe;
    serial_port_enable && !sync |=> transmit_clock_pin_oe == $past(transmit_enable_bit) && !receive_data_pin_oe;
  endproperty
  a_async_oe: assert property (p_async_oe) else $error("async pin direction");
  property p_master;
    serial_port_enable && sync |=> transmit_clock_pin_oe == $past(clock_source_select);
  endproperty
  a_master: assert property (p_master) else $error("sync clock direction");
  property p_sync_dt;
    serial_port_enable && sync |=> receive_data_pin_oe == $past(dt_en);
  endproperty
  a_sync_dt: assert property (p_sync_dt) else $error("sync data direction");
  property p_bit;
    ok_reg && $rose(transmit_clock_pin_out) |-> lo_reg[5:0] == 6'h00 && lo_reg != 10'h000;
  endproperty
  a_bit: assert property (p_bit) else $error("async bit length wrong");
endmodule : usm_checker

//--- dv/usm_peer.sv
`timescale 1ns/1ps
// ********
// Serial peer
// ********
module usm_peer (
  input  wire logic       sys_clk,
  input  wire logic       tx_line,
  input  wire logic       dt_line,
  input  wire logic       listen,
  input  wire logic       sync_mode,
  input  wire logic       nine,
  input  wire logic [9:0] bit_cyc,
  input  wire logic       slv_go,
  output logic            slv_clk,
  output logic      [8:0] word,
  output logic            stop_ok,
  output int              frames
);
  int n;
  initial begin
    slv_clk = 1'b0;
    frames = 0;
    n = 0;
  end

  // Async receive, each bit sampled mid-cell
  always @(negedge tx_line) begin
    if (listen && !sync_mode) begin
      word = 9'h000;
      repeat (bit_cyc / 2) @(posedge sys_clk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_cyc) @(posedge sys_clk);
        word[i] = tx_line;
      end
      repeat (bit_cyc) @(posedge sys_clk);
      stop_ok = tx_line;
      frames++;
    end
  end

  // Sync receive on rising clock, LSB first
  always @(posedge tx_line) begin
    if (listen && sync_mode) begin
      word[n] = dt_line;
      n++;
      if (n == (nine ? 9 : 8)) begin
        frames++;
        n = 0;
      end
    end
  end

  // Fresh bit count and word when listening starts
  always @(posedge listen) begin
    n = 0;
    word = 9'h000;
  end

  // Slave clock: one burst per request, idle low
  always @(posedge slv_go) begin
    repeat (nine ? 9 : 8) begin
      repeat (20) @(negedge sys_clk);
      slv_clk = 1'b1;
      repeat (20) @(negedge sys_clk);
      slv_clk = 1'b0;
    end
  end
endmodule : usm_peer

//--- rtl/usm_map.svh
`ifndef USM_MAP_SVH
`define USM_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define USM_OFF_RXCTL      8'h13
`define USM_OFF_TXCTL      8'h15
`define USM_OFF_TXDATA     8'h16
`define USM_OFF_DIVISOR    8'h17
`define USM_OFF_IRQ_STAT   8'h18
`define USM_OFF_IRQ_MASK   8'h19

// ****************************************************************
// Field positions
// ****************************************************************
`define USM_TX_CLOCK_SOURCE_SELECT        7
`define USM_TX_NINE        6
`define USM_TX_EN          5
`define USM_TX_SYNC        4
`define USM_TX_EMPTY       1
`define USM_TX_D9          0
`define USM_RX_SERIAL_PORT_ENABLE        7
`define USM_RX_NINE        6
`define USM_RX_SINGLE_RECEIVE_ENABLE        5
`define USM_RX_CONTINUOUS_RECEIVE_ENABLE        4
`define USM_IRQ_BUF        0
`define USM_IRQ_DONE       1

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define USM_TXCTL_RST      8'h00
`define USM_RXCTL_RST      8'h00
`define USM_DIVISOR_RST    8'h00
`define USM_IRQ_RST        2'h0
`define USM_TXCTL_WMASK    8'hf1
`define USM_RXCTL_WMASK    8'hf0

// ****************************************************************
// Timing counts
// ****************************************************************
`define USM_ASYNC_TICKS    7'h40
`define USM_SYNC_TICKS     7'h04
`define USM_ASYNC_BITS8    4'ha
`define USM_ASYNC_BITS9    4'hb
`define USM_SYNC_BITS8     4'h8
`define USM_SYNC_BITS9     4'h9

`endif

//--- rtl/usm_pkg.sv
package usm_pkg;

  // Shifter state, one-hot
  typedef enum logic [1:0] {
    USM_IDLE  = 2'b01,
    USM_SHIFT = 2'b10
  } usm_state_t;

endpackage : usm_pkg

//--- rtl/usm_top.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "usm_map.svh"
// Overview of operation
// - Three modes: asynchronous full duplex, synchronous master, synchronous slave.
// - Pins serve the serial port only while port enable is set.
// - Port drives both pin directions from enable, transmit, receive, clock bits.
// - Synchronous: clock select set means master on baud clock, else slave.
// - Nine-bit select chooses nine-bit or eight-bit transmission.
// - Transmit enable gates transmission; sync receive enables override it.
// - Synchronous select bit picks synchronous or asynchronous mode.
// - Bits three and two of transmit control always read zero.
// - Read-only flag is one while shifter is empty; resets to one.
// - Writable ninth data bit is sent when nine-bit transmission is selected.
// - Baud is clock over 64(X+1) async, over 4(X+1) sync master.
// - Writing the baud divisor clears the baud generator timer.
module usm_top (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  input  wire logic       receive_data_pin_in,
  output logic            receive_data_pin_out,
  output logic            receive_data_pin_oe,
  input  wire logic       transmit_clock_pin_in,
  output logic            transmit_clock_pin_out,
  output logic            transmit_clock_pin_oe,
  input  wire logic       gpio_data_out,
  input  wire logic       gpio_data_oe,
  input  wire logic       gpio_clock_out,
  input  wire logic       gpio_clock_oe
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Address match for one register
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  // Number of bit slots in one frame
  function automatic logic [3:0] frame_len(input logic sync, input logic nine);
    if (sync) begin
      frame_len = nine ? `USM_SYNC_BITS9 : `USM_SYNC_BITS8;
    end else begin
      frame_len = nine ? `USM_ASYNC_BITS9 : `USM_ASYNC_BITS8;
    end
  endfunction : frame_len

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]          txctl_reg;
  logic [7:0]          txctl_next;
  logic [7:0]          rxctl_reg;
  logic [7:0]          rxctl_next;
  logic [7:0]          divisor_reg;
  logic [7:0]          divisor_next;
  logic [7:0]          txbuf_reg;
  logic [7:0]          txbuf_next;
  logic                buf_full_reg;
  logic                buf_full_next;
  logic [1:0]          stat_reg;
  logic [1:0]          stat_next;
  logic [1:0]          mask_reg;
  logic [1:0]          mask_next;
  logic                irq_reg;
  logic [7:0]          rdata_reg;
  logic [7:0]          rdata_next;
  logic [7:0]          brg_cnt_reg;
  logic [7:0]          brg_cnt_next;
  logic [5:0]          phase_reg;
  logic [5:0]          phase_next;
  usm_pkg::usm_state_t state_reg;
  usm_pkg::usm_state_t state_next;
  logic [10:0]         shreg_reg;
  logic [10:0]         shreg_next;
  logic [3:0]          bit_cnt_reg;
  logic [3:0]          bit_cnt_next;
  logic                ck_sync1_reg;
  logic                ck_sync2_reg;
  logic                ck_prev_reg;
  logic                dt_out_reg;
  logic                dt_oe_reg;
  logic                ck_out_reg;
  logic                ck_oe_reg;

  // ****************************************************************
  // Register decode
  // ****************************************************************

  // Write strobes per register
  wire wr_txctl  = reg_wr & reg_hit(reg_addr, `USM_OFF_TXCTL);
  wire wr_rxctl  = reg_wr & reg_hit(reg_addr, `USM_OFF_RXCTL);
  wire wr_txdata = reg_wr & reg_hit(reg_addr, `USM_OFF_TXDATA);
  wire wr_div    = reg_wr & reg_hit(reg_addr, `USM_OFF_DIVISOR);
  wire wr_stat   = reg_wr & reg_hit(reg_addr, `USM_OFF_IRQ_STAT);
  wire wr_mask   = reg_wr & reg_hit(reg_addr, `USM_OFF_IRQ_MASK);

  // Configuration fields
  wire port_en   = rxctl_reg[`USM_RX_SERIAL_PORT_ENABLE];
  wire sync_mode = txctl_reg[`USM_TX_SYNC];
  wire clk_src   = txctl_reg[`USM_TX_CLOCK_SOURCE_SELECT];
  wire nine_bit  = txctl_reg[`USM_TX_NINE];
  wire ninth_bit = txctl_reg[`USM_TX_D9];
  wire tx_en_bit = txctl_reg[`USM_TX_EN];
  wire rx_req    = rxctl_reg[`USM_RX_SINGLE_RECEIVE_ENABLE] | rxctl_reg[`USM_RX_CONTINUOUS_RECEIVE_ENABLE];

  // Mode selection: clock select only counts in synchronous mode
  wire is_master = sync_mode & clk_src;
  wire is_slave  = sync_mode & ~clk_src;

  // Receive enables win over transmit enable in synchronous mode
  wire tx_active = port_en & tx_en_bit & ~(sync_mode & rx_req);

  // ****************************************************************
  // Register next values
  // ****************************************************************

  // Control registers keep only implemented bits
  assign txctl_next   = wr_txctl ? (reg_wdata & `USM_TXCTL_WMASK) : txctl_reg;
  assign rxctl_next   = wr_rxctl ? (reg_wdata & `USM_RXCTL_WMASK) : rxctl_reg;
  assign divisor_next = wr_div ? reg_wdata : divisor_reg;
  assign mask_next    = wr_mask ? reg_wdata[1:0] : mask_reg;

  // Holding buffer: a write while full is ignored
  wire buf_take  = wr_txdata & ~buf_full_reg;
  wire shf_idle  = (state_reg == usm_pkg::USM_IDLE);
  wire load      = shf_idle & buf_full_reg & tx_active;
  assign txbuf_next    = buf_take ? reg_wdata : txbuf_reg;
  assign buf_full_next = buf_take | (buf_full_reg & ~load);

  // ****************************************************************
  // Baud generator
  // ****************************************************************

  // Free-running timer, period divisor plus one clocks
  wire brg_tick = (brg_cnt_reg == divisor_reg);
  assign brg_cnt_next = (wr_div | brg_tick) ? 8'h00 : brg_cnt_reg + 8'h01;

  // Sub-bit phase: 64 ticks per bit async, 4 per bit sync
  wire [6:0] ticks_per_bit = sync_mode ? `USM_SYNC_TICKS : `USM_ASYNC_TICKS;
  wire [6:0] phase_last_w  = ticks_per_bit - 7'h01;
  wire       phase_wrap    = brg_tick & (phase_reg == phase_last_w[5:0]);
  assign phase_next = (wr_div | shf_idle | phase_wrap) ? 6'h00 :
                      brg_tick ? phase_reg + 6'h01 : phase_reg;

  // ****************************************************************
  // External clock for slave mode
  // ****************************************************************

  // Falling edge of the synchronised pin clock
  wire ck_fall = ck_prev_reg & ~ck_sync2_reg;

  // ****************************************************************
  // Transmit shifter
  // ****************************************************************

  // Frame word: async adds start and stop, ninth bit only when selected
  wire        d9_or_stop = nine_bit ? ninth_bit : 1'b1;
  wire [10:0] async_word = {1'b1, d9_or_stop, txbuf_reg, 1'b0};
  wire [10:0] sync_word  = {2'b11, d9_or_stop, txbuf_reg};
  wire [10:0] load_word  = sync_mode ? sync_word : async_word;

  // Bit timing: slave follows pin clock, others the baud phase
  wire       bit_tick = is_slave ? ck_fall : phase_wrap;
  wire [3:0] nbits    = frame_len(sync_mode, nine_bit);
  wire [3:0] last_idx = nbits - 4'h1;
  wire       advance  = ~shf_idle & bit_tick;
  wire       finish   = advance & (bit_cnt_reg == last_idx);
  wire       abort    = ~shf_idle & ~tx_active;

  // State transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      usm_pkg::USM_IDLE: begin
        if (load) begin
          state_next = usm_pkg::USM_SHIFT;
        end
      end
      usm_pkg::USM_SHIFT: begin
        if (abort | finish) begin
          state_next = usm_pkg::USM_IDLE;
        end
      end
    endcase
  end

  // Shift data out LSB first, fill with ones
  assign shreg_next   = load ? load_word :
                        advance ? {1'b1, shreg_reg[10:1]} : shreg_reg;
  assign bit_cnt_next = load ? 4'h0 :
                        advance ? bit_cnt_reg + 4'h1 : bit_cnt_reg;

  // Shifter empty flag
  wire shifter_empty_flag = shf_idle;

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************

  // Buffer handed to shifter, and frame completed
  wire [1:0] ev_set = {finish, load};
  wire [1:0] ev_clr = wr_stat ? reg_wdata[1:0] : 2'h0;
  // Set wins over a simultaneous clear
  assign stat_next = ev_set | (stat_reg & ~ev_clr);

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Transmit control with live empty flag, unimplemented bits zero
  wire [7:0] txctl_rd = {txctl_reg[7:4], 2'b00, shifter_empty_flag, txctl_reg[0]};
  wire [7:0] rxctl_rd = {rxctl_reg[7:4], 4'h0};

  // Read mux, zero on unmapped or write-only offsets
  wire [7:0] rd_mux =
    reg_hit(reg_addr, `USM_OFF_TXCTL)    ? txctl_rd :
    reg_hit(reg_addr, `USM_OFF_RXCTL)    ? rxctl_rd :
    reg_hit(reg_addr, `USM_OFF_DIVISOR)  ? divisor_reg :
    reg_hit(reg_addr, `USM_OFF_IRQ_STAT) ? {6'h00, stat_reg} :
    reg_hit(reg_addr, `USM_OFF_IRQ_MASK) ? {6'h00, mask_reg} : 8'h00;
  assign rdata_next = reg_rd ? rd_mux : 8'h00;

  // ****************************************************************
  // Pin muxing and direction
  // ****************************************************************

  // Serial line level and master clock
  wire serial_bit = shf_idle ? 1'b1 : shreg_reg[0];
  wire master_ck  = ~shf_idle & phase_reg[1];

  // Data pin: output only while transmitting in sync mode
  wire dt_oe_next  = port_en ? (sync_mode & tx_active) : gpio_data_oe;
  wire dt_out_next = port_en ? serial_bit : gpio_data_out;

  // Clock pin: async line when enabled, master clock, slave input
  wire ck_oe_sel   = sync_mode ? clk_src : tx_en_bit;
  wire ck_oe_next  = port_en ? ck_oe_sel : gpio_clock_oe;
  wire ck_val      = is_master ? master_ck : (sync_mode ? 1'b0 : serial_bit);
  wire ck_out_next = port_en ? ck_val : gpio_clock_out;

  // ****************************************************************
  // Flip-flops
  // ****************************************************************

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txctl_reg   <= `USM_TXCTL_RST;
      rxctl_reg   <= `USM_RXCTL_RST;
      divisor_reg <= `USM_DIVISOR_RST;
      mask_reg    <= `USM_IRQ_RST;
    end else begin
      txctl_reg   <= txctl_next;
      rxctl_reg   <= rxctl_next;
      divisor_reg <= divisor_next;
      mask_reg    <= mask_next;
    end
  end

  // Buffer, status, interrupt and read data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txbuf_reg    <= 8'h00;
      buf_full_reg <= 1'b0;
      stat_reg     <= `USM_IRQ_RST;
      irq_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      txbuf_reg    <= txbuf_next;
      buf_full_reg <= buf_full_next;
      stat_reg     <= stat_next;
      irq_reg      <= |(stat_next & mask_next);
      rdata_reg    <= rdata_next;
    end
  end

  // Baud generator and phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      brg_cnt_reg <= 8'h00;
      phase_reg   <= 6'h00;
    end else begin
      brg_cnt_reg <= brg_cnt_next;
      phase_reg   <= phase_next;
    end
  end

  // Shifter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg   <= usm_pkg::USM_IDLE;
      shreg_reg   <= 11'h7ff;
      bit_cnt_reg <= 4'h0;
    end else begin
      state_reg   <= state_next;
      shreg_reg   <= shreg_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // Pin clock synchroniser and edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ck_sync1_reg <= 1'b0;
      ck_sync2_reg <= 1'b0;
      ck_prev_reg  <= 1'b0;
    end else begin
      ck_sync1_reg <= transmit_clock_pin_in;
      ck_sync2_reg <= ck_sync1_reg;
      ck_prev_reg  <= ck_sync2_reg;
    end
  end

  // Registered pin drive
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dt_out_reg <= 1'b0;
      dt_oe_reg  <= 1'b0;
      ck_out_reg <= 1'b0;
      ck_oe_reg  <= 1'b0;
    end else begin
      dt_out_reg <= dt_out_next;
      dt_oe_reg  <= dt_oe_next;
      ck_out_reg <= ck_out_next;
      ck_oe_reg  <= ck_oe_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Receive data pin level is left to the receiver
  wire unused_rx = receive_data_pin_in;

  assign reg_rdata              = rdata_reg;
  assign irq                    = irq_reg;
  assign receive_data_pin_out   = dt_out_reg;
  assign receive_data_pin_oe    = dt_oe_reg;
  assign transmit_clock_pin_out = ck_out_reg;
  assign transmit_clock_pin_oe  = ck_oe_reg;

endmodule : usm_top
